/* File: core/rtd_slave_status.sv */
// Behaviour
// - Station number is inverted switch value minus one
// - Switches seven and eight pick sensor types
// - Each word tied to one fixed terminal
// - All eight inputs given as words
// - Temperatures at offsets 0-10, voltages 12, 14
// - Power indicator lit when supply good, ready
// - Bus indicator dark while master halted without error
// - Bus indicator steady while running without error
// - Bus indicator flashes on transfer error
// - General diagnostic byte bit layout fixed
// - Sensor byte bits 0-5 flag channel faults
// - Wire break substitutes +3000 or +1500
// - Short circuit substitutes -1000 or -500
// - Missing sensor raises fault indication
// - Voltage codes are 12-bit unsigned steps
// - Voltage word upper four bits zero
// - Temperature words signed tenths of degree
`timescale 1ns/100ps
`include "rtd_slave_defines.svh"

module rtd_slave_status
   import rtd_slave_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
)
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic            clockEnable,
   input  wire logic [7:0]      configSwitchPin,
   input  wire logic            supplyGoodPin,
   input  wire word_t           tempSample [`NUM_TEMP],
   input  wire logic [5:0]      tempUpdate,
   input  wire logic [5:0]      tempWireBreak,
   input  wire logic [5:0]      tempShort,
   input  wire voltCode_t       voltSample [`NUM_VOLT],
   input  wire logic [1:0]      voltUpdate,
   input  wire logic            masterRun,
   input  wire logic            linkError,
   input  wire logic            lengthError,
   input  wire logic            hwError,
   input  wire logic            typeError,
   input  wire logic            readStrobe,
   input  wire logic [3:0]      readOffset,
   output word_t                readWord,
   output logic                 readValid,
   output logic [7:0]           diagGeneral,
   output logic [7:0]           diagSensor,
   output logic [4:0]           stationNumber,
   output logic                 addressValid,
   output logic [5:0]           sensorNickel,
   output logic                 powerLed,
   output logic                 busLed
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   sensor_cfg_if cfg ();

   word_t      inputWord [`NUM_WORDS];
   word_t      substWord [`NUM_TEMP];
   logic [5:0] sensorFault;
   logic       supplyMeta;
   logic       supplySync;
   busState_t  busState;
   busState_t  next_busState;
   logic [31:0] blinkCount;
   logic       blinkPhase;
   logic [7:0] next_diagGeneral;

   // ----------------------------------------
   // Configuration switches
   // ----------------------------------------
   switch_decoder switchDecoder
   (
      .clock       (clock),
      .rst         (rst),
      .clockEnable (clockEnable),
      .switchPin   (configSwitchPin),
      .cfg         (cfg.producer)
   );

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stationNumber <= 5'h00;
         addressValid  <= 1'b0;
         sensorNickel  <= 6'h00;
      end
      else if (clockEnable)
      begin
         stationNumber <= cfg.station;
         addressValid  <= cfg.addrValid;
         sensorNickel  <= cfg.nickel;
      end
   end

   // ----------------------------------------
   // Fault substitution per channel
   // ----------------------------------------
   // Type follows the terminal, never the reverse
   generate
      for (genvar i = 0; i < `NUM_TEMP; i++)
      begin : gen_channel
         fault_substitute channelSubst
         (
            .sample       (tempSample[i]),
            .wireBreak    (tempWireBreak[i]),
            .shortCircuit (tempShort[i]),
            .nickel       (cfg.nickel[i]),
            .word         (substWord[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // Input word image
   // ----------------------------------------
   // Words only move after configuration is known, so a word never
   // carries a substitution value for the wrong sensor type
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < `NUM_WORDS; i++)
            inputWord[i] <= 16'sh0000;
      end
      else if (clockEnable && cfg.ready)
      begin
         for (int i = 0; i < `NUM_TEMP; i++)
            if (tempUpdate[i])
               inputWord[i] <= substWord[i];
         for (int v = 0; v < `NUM_VOLT; v++)
            if (voltUpdate[v])
               inputWord[`NUM_TEMP + v] <= {`VOLT_PAD_BITS'h0, voltSample[v]};
      end
   end

   // ----------------------------------------
   // Sensor fault flags
   // ----------------------------------------
   // An unconnected input looks like a break to the front end
   always_ff @(posedge clock)
   begin
      if (rst)
         sensorFault <= 6'h00;
      else if (clockEnable && cfg.ready)
      begin
         for (int i = 0; i < `NUM_TEMP; i++)
            if (tempUpdate[i])
               sensorFault[i] <= tempWireBreak[i] | tempShort[i];
      end
   end

   // ----------------------------------------
   // Master read port
   // ----------------------------------------
   // Odd offsets fold onto their even word
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         readWord  <= 16'sh0000;
         readValid <= 1'b0;
      end
      else if (clockEnable)
      begin
         readValid <= readStrobe;
         if (readStrobe)
            readWord <= inputWord[readOffset[3:1]];
      end
   end

   // ----------------------------------------
   // Diagnostic bytes
   // ----------------------------------------
   always_comb
   begin
      next_diagGeneral                   = 8'h00;
      next_diagGeneral[`DIAG_HALT_BIT]   = !masterRun;
      next_diagGeneral[`DIAG_LENGTH_BIT] = lengthError;
      next_diagGeneral[`DIAG_HW_BIT]     = hwError;
      next_diagGeneral[`DIAG_SENSOR_BIT] = |sensorFault;
      next_diagGeneral[`DIAG_NOCONN_BIT] = linkError;
      next_diagGeneral[`DIAG_TYPE_BIT]   = typeError;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         diagGeneral <= 8'h00;
         diagSensor  <= 8'h00;
      end
      else if (clockEnable)
      begin
         diagGeneral <= next_diagGeneral;
         diagSensor  <= {2'h0, sensorFault};
      end
   end

   // ----------------------------------------
   // Power indicator
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         supplyMeta <= 1'b0;
         supplySync <= 1'b0;
      end
      else if (clockEnable)
      begin
         supplyMeta <= supplyGoodPin;
         supplySync <= supplyMeta;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         powerLed <= 1'b0;
      else if (clockEnable)
         powerLed <= supplySync && cfg.ready;
   end

   // ----------------------------------------
   // Bus indicator state
   // ----------------------------------------
   // Error outranks run: a running master that cannot reach us still flashes
   always_comb
   begin
      case (busState)
         BUS_HALT,
         BUS_RUN,
         BUS_FLASH:
         begin
            if (linkError)
               next_busState = BUS_FLASH;
            else if (masterRun)
               next_busState = BUS_RUN;
            else
               next_busState = BUS_HALT;
         end
         default:
            next_busState = BUS_HALT;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         busState <= BUS_HALT;
      else if (clockEnable)
         busState <= next_busState;
   end

   // Blink timer restarts on entry so the first flash is a full half period
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         blinkCount <= 32'h0000_0000;
         blinkPhase <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (busState != BUS_FLASH)
         begin
            blinkCount <= 32'h0000_0000;
            blinkPhase <= 1'b1;
         end
         else if (blinkCount >= 32'(BLINK_HALF_CYCLES - 1))
         begin
            blinkCount <= 32'h0000_0000;
            blinkPhase <= !blinkPhase;
         end
         else
         begin
            blinkCount <= 32'(blinkCount + 32'h1);
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         busLed <= 1'b0;
      else if (clockEnable)
      begin
         case (busState)
            BUS_HALT:  busLed <= 1'b0;
            BUS_RUN:   busLed <= 1'b1;
            BUS_FLASH: busLed <= blinkPhase;
            default:   busLed <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sensor_type_a : assert property (@(posedge clock) disable iff (rst)
      cfg.ready |-> cfg.nickel[3:0] == {4{cfg.nickel[0]}}
                 && cfg.nickel[5:4] == {2{cfg.nickel[4]}})
      else $error("Sensor groups split inside a group");

   temp_word_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && cfg.ready && tempUpdate[0] && !tempWireBreak[0] && !tempShort[0]
      |=> inputWord[0] == $past(tempSample[0]))
      else $error("Channel 0 word not taken from its terminal");

   read_map_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && readStrobe && readOffset == `WORD_OFS_VOLT1
      |=> readValid && readWord == $past(inputWord[7]))
      else $error("Offset 14 did not return second voltage word");

   break_value_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && cfg.ready && tempUpdate[5] && tempWireBreak[5]
      |=> inputWord[5] == (cfg.nickel[5] ? `NI_BREAK_VALUE : `PT_BREAK_VALUE)
          && sensorFault[5])
      else $error("Wire break value wrong on channel 5");

   short_value_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && cfg.ready && tempUpdate[1] && tempShort[1] && !tempWireBreak[1]
      |=> inputWord[1] == (cfg.nickel[1] ? `NI_SHORT_VALUE : `PT_SHORT_VALUE))
      else $error("Short circuit value wrong on channel 1");

   volt_pad_a : assert property (@(posedge clock) disable iff (rst)
      inputWord[6][15:12] == 4'h0 && inputWord[7][15:12] == 4'h0)
      else $error("Voltage word upper bits not zero");

   diag_group_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable |=> diagGeneral[`DIAG_SENSOR_BIT] == |$past(sensorFault)
                   && diagGeneral[0] == 1'b0 && diagGeneral[3] == 1'b0)
      else $error("General diagnostic byte layout wrong");

   diag_sensor_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable |=> diagSensor == {2'h0, $past(sensorFault)})
      else $error("Sensor diagnostic byte wrong");

   power_led_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && !supplySync |=> !powerLed)
      else $error("Power indicator lit without supply");

   halt_dark_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && busState == BUS_HALT |=> !busLed)
      else $error("Bus indicator lit while halted");

   run_steady_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && !linkError && masterRun ##1 clockEnable |=> busLed)
      else $error("Bus indicator not steady while running");

   flash_toggle_a : assert property (@(posedge clock) disable iff (rst)
      clockEnable && busState == BUS_FLASH && blinkCount >= 32'(BLINK_HALF_CYCLES - 1)
      |=> blinkPhase != $past(blinkPhase))
      else $error("Flash phase did not toggle");

   run_seen_c : cover property (@(posedge clock) disable iff (rst)
      busState == BUS_RUN && busLed);

   flash_seen_c : cover property (@(posedge clock) disable iff (rst)
      busState == BUS_FLASH && $fell(busLed));

   fault_read_c : cover property (@(posedge clock) disable iff (rst)
      diagGeneral[`DIAG_SENSOR_BIT] ##1 readValid);

endmodule

/* File: core/rtd_slave_defines.svh */
`ifndef RTD_SLAVE_DEFINES_SVH
`define RTD_SLAVE_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_HZ             10000000
`define BLINK_HALF_MS        250
`define BLINK_HALF_CYCLES    ((`CLOCK_HZ / 1000) * `BLINK_HALF_MS)
`define SWITCH_SETTLE_CYCLES 4

// ----------------------------------------
// Configuration switch layout
// ----------------------------------------
`define ADDR_SW_WIDTH        5
`define SEL_GROUP_A_SW       6
`define SEL_GROUP_B_SW       7
`define GROUP_A_LAST         3

// ----------------------------------------
// Input word byte offsets
// ----------------------------------------
`define NUM_TEMP             6
`define NUM_VOLT             2
`define NUM_WORDS            8
`define WORD_OFS_TEMP0       4'h0
`define WORD_OFS_VOLT0       4'hC
`define WORD_OFS_VOLT1       4'hE
`define VOLT_PAD_BITS        4

// ----------------------------------------
// Diagnostic bit positions
// ----------------------------------------
`define DIAG_HALT_BIT        1
`define DIAG_LENGTH_BIT      2
`define DIAG_HW_BIT          4
`define DIAG_SENSOR_BIT      5
`define DIAG_NOCONN_BIT      6
`define DIAG_TYPE_BIT        7

// ----------------------------------------
// Fault substitution values, tenths of a degree
// ----------------------------------------
`define PT_BREAK_VALUE       16'sh0BB8
`define NI_BREAK_VALUE       16'sh05DC
`define PT_SHORT_VALUE       16'shFC18
`define NI_SHORT_VALUE       16'shFE0C

`endif

/* File: core/rtd_slave_pkg.sv */
package rtd_slave_pkg;

   typedef enum logic [2:0]
   {
      BUS_HALT  = 3'b001,
      BUS_RUN   = 3'b010,
      BUS_FLASH = 3'b100
   } busState_t;

   typedef logic signed [15:0] word_t;
   typedef logic [11:0]        voltCode_t;

endpackage

/* File: core/sensor_cfg_if.sv */
`timescale 1ns/100ps

interface sensor_cfg_if;
   logic [4:0] station;
   logic       addrValid;
   logic [5:0] nickel;
   logic       ready;

   modport producer
   (
      output station,
      output addrValid,
      output nickel,
      output ready
   );

   modport consumer
   (
      input station,
      input addrValid,
      input nickel,
      input ready
   );
endinterface

/* File: core/switch_decoder.sv */
`timescale 1ns/100ps
`include "rtd_slave_defines.svh"

module switch_decoder
   import rtd_slave_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clockEnable,
   input  wire logic [7:0] switchPin,
   sensor_cfg_if.producer  cfg
);

   logic [7:0] switchMeta;
   logic [7:0] switchSync;
   logic [2:0] settleCount;
   logic [4:0] inverted;

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         switchMeta <= 8'h00;
         switchSync <= 8'h00;
      end
      else if (clockEnable)
      begin
         switchMeta <= switchPin;
         switchSync <= switchMeta;
      end
   end

   assign inverted = ~switchSync[`ADDR_SW_WIDTH-1:0];

   // ----------------------------------------
   // One-shot capture after reset
   // ----------------------------------------
   // Switches moved later are ignored until the next reset
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         settleCount   <= 3'h0;
         cfg.ready     <= 1'b0;
         cfg.station   <= 5'h00;
         cfg.addrValid <= 1'b0;
         cfg.nickel    <= 6'h00;
      end
      else if (clockEnable && !cfg.ready)
      begin
         if (settleCount == 3'(`SWITCH_SETTLE_CYCLES))
         begin
            cfg.ready     <= 1'b1;
            cfg.station   <= 5'(inverted - 5'h01);
            cfg.addrValid <= (inverted > 5'h01);
            cfg.nickel    <= {{2{switchSync[`SEL_GROUP_B_SW]}},
                              {4{switchSync[`SEL_GROUP_A_SW]}}};
         end
         else
         begin
            settleCount <= 3'(settleCount + 3'h1);
         end
      end
   end

   station_map_a : assert property (@(posedge clock) disable iff (rst)
      $rose(cfg.ready) |-> cfg.station == 5'(~$past(switchSync[4:0]) - 5'h01))
      else $error("Station number does not match switches");

   capture_once_a : assert property (@(posedge clock) disable iff (rst)
      cfg.ready && $past(cfg.ready) |-> $stable(cfg.nickel) && $stable(cfg.station))
      else $error("Configuration changed after capture");

endmodule

/* File: core/fault_substitute.sv */
`timescale 1ns/100ps
`include "rtd_slave_defines.svh"

module fault_substitute
   import rtd_slave_pkg::*;
(
   input  wire word_t sample,
   input  wire logic  wireBreak,
   input  wire logic  shortCircuit,
   input  wire logic  nickel,
   output word_t      word
);

   // Break outranks short: an open loop can also read as a low value
   always_comb
   begin
      if (wireBreak)
         word = nickel ? `NI_BREAK_VALUE : `PT_BREAK_VALUE;
      else if (shortCircuit)
         word = nickel ? `NI_SHORT_VALUE : `PT_SHORT_VALUE;
      else
         word = sample;
   end

endmodule

/* File: bench/fieldbus_master_model.sv */
`timescale 1ns/100ps

module fieldbus_master_model
   import rtd_slave_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  readValid,
   input  wire word_t readWord,
   output logic       masterRun,
   output logic       linkError,
   output logic       readStrobe,
   output logic [3:0] readOffset
);
   initial
   begin
      masterRun  = 1'b0;
      linkError  = 1'b0;
      readStrobe = 1'b0;
      readOffset = 4'h0;
   end

   task automatic set_bus(input logic run, input logic err);
      @(posedge clock);
      masterRun <= run;
      linkError <= err;
   endtask

   // Offset scrambled after the strobe, so a stale address cannot pass
   task automatic read_word(input logic [3:0] ofs, output logic valid, output word_t w);
      @(posedge clock);
      readStrobe <= 1'b1;
      readOffset <= ofs;
      @(posedge clock);
      readStrobe <= 1'b0;
      readOffset <= ~ofs;
      #1;
      valid = readValid;
      w = readWord;
   endtask
endmodule

/* File: bench/rtd_slave_status_tb.sv */
`timescale 1ns/100ps
`define CHECK(got, exp) \
   begin \
      nCompared++; \
      if ((got) !== (exp)) \
      begin \
         failCount++; \
         $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module rtd_slave_status_tb
   import rtd_slave_pkg::*;
;
   localparam int BLINK = 8;
   logic       clock;
   logic       rst;
   logic       clockEnable;
   logic [7:0] configSwitchPin;
   logic       supplyGoodPin;
   word_t      tempSample [6];
   logic [5:0] tempUpdate;
   logic [5:0] tempWireBreak;
   logic [5:0] tempShort;
   voltCode_t  voltSample [2];
   logic [1:0] voltUpdate;
   logic       masterRun;
   logic       linkError;
   logic       lengthError;
   logic       hwError;
   logic       typeError;
   logic       readStrobe;
   logic [3:0] readOffset;
   word_t      readWord;
   logic       readValid;
   logic [7:0] diagGeneral;
   logic [7:0] diagSensor;
   logic [4:0] stationNumber;
   logic       addressValid;
   logic [5:0] sensorNickel;
   logic       powerLed;
   logic       busLed;
   int         failCount = 0;
   int         nCompared = 0;
   int         expWord [8];
   logic [5:0] expFault;

   rtd_slave_status #(.BLINK_HALF_CYCLES(BLINK)) uut
   (
      .clock(clock),
      .rst(rst),
      .clockEnable(clockEnable),
      .configSwitchPin(configSwitchPin),
      .supplyGoodPin(supplyGoodPin),
      .tempSample(tempSample),
      .tempUpdate(tempUpdate),
      .tempWireBreak(tempWireBreak),
      .tempShort(tempShort),
      .voltSample(voltSample),
      .voltUpdate(voltUpdate),
      .masterRun(masterRun),
      .linkError(linkError),
      .lengthError(lengthError),
      .hwError(hwError),
      .typeError(typeError),
      .readStrobe(readStrobe),
      .readOffset(readOffset),
      .readWord(readWord),
      .readValid(readValid),
      .diagGeneral(diagGeneral),
      .diagSensor(diagSensor),
      .stationNumber(stationNumber),
      .addressValid(addressValid),
      .sensorNickel(sensorNickel),
      .powerLed(powerLed),
      .busLed(busLed)
   );

   fieldbus_master_model master
   (
      .clock(clock),
      .readValid(readValid),
      .readWord(readWord),
      .masterRun(masterRun),
      .linkError(linkError),
      .readStrobe(readStrobe),
      .readOffset(readOffset)
   );

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ----------------------------------------
   // Reference model and helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   function automatic logic [7:0] exp_general();
      return {typeError, linkError, |expFault, hwError, 1'b0, lengthError, ~masterRun, 1'b0};
   endfunction

   task automatic read_check(input logic [3:0] ofs, input word_t exp);
      logic  valid;
      word_t w;
      master.read_word(ofs, valid, w);
      `CHECK(valid, 1'b1)
      `CHECK(w, exp)
   endtask

   task automatic load_temp(input int i, input logic [1:0] kind, input logic nickel);
      word_t s;
      s = word_t'($urandom_range(4000) - 1000);
      @(posedge clock);
      tempSample[i] <= s;
      tempWireBreak[i] <= kind[0];
      tempShort[i] <= kind[1];
      tempUpdate[i] <= 1'b1;
      @(posedge clock);
      tempUpdate[i] <= 1'b0;
      expFault[i] = kind != 2'b00;
      if (kind[0])
         expWord[i] = nickel ? 1500 : 3000;
      else if (kind[1])
         expWord[i] = nickel ? -500 : -1000;
      else
         expWord[i] = s;
   endtask

   task automatic load_volt(input int v, input voltCode_t c);
      @(posedge clock);
      voltSample[v] <= c;
      voltUpdate[v] <= 1'b1;
      @(posedge clock);
      voltUpdate[v] <= 1'b0;
      expWord[6 + v] = {4'h0, c};
   endtask

   // Config is only taken after reset, so each mode needs its own reset
   task automatic run_config(input logic [1:0] mode);
      logic [4:0] station;
      logic [5:0] nickel;
      station = 5'($urandom_range(30, 1));
      nickel = {{2{mode[0]}}, {4{mode[1]}}};
      expFault = 6'h00;
      @(posedge clock);
      configSwitchPin <= {mode[0], mode[1], 1'($urandom), ~(station + 5'h01)};
      lengthError <= 1'($urandom);
      hwError <= 1'($urandom);
      typeError <= 1'($urandom);
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      tempUpdate <= 6'h3F;
      tempWireBreak <= 6'h3F;
      @(posedge clock);
      tempUpdate <= 6'h00;
      repeat (12) @(posedge clock);
      #1;
      `CHECK(stationNumber, station)
      `CHECK(addressValid, 1'b1)
      `CHECK(sensorNickel, nickel)
      `CHECK(powerLed, 1'b1)
      `CHECK(diagSensor, 8'h00)
      read_check(4'h0, 16'sh0000);
      @(posedge clock);
      configSwitchPin <= ~configSwitchPin;
      for (int i = 0; i < 6; i++)
      begin
         load_temp(i, 2'($urandom), nickel[i]);
         read_check(4'(2 * i) | 4'($urandom_range(1)), word_t'(expWord[i]));
      end
      load_volt(0, (mode == 2'h0) ? 12'h000 : 12'($urandom));
      load_volt(1, (mode == 2'h3) ? 12'hFFF : 12'($urandom));
      for (int k = 0; k < 16; k++)
         read_check(4'(k), word_t'(expWord[k / 2]));
      `CHECK(diagSensor, {2'b00, expFault})
      `CHECK(diagGeneral, exp_general())
      `CHECK(stationNumber, station)
      `CHECK(sensorNickel, nickel)
   endtask

   task automatic bus_state(input logic run, input logic err, input logic lit);
      master.set_bus(run, err);
      repeat (3) @(posedge clock);
      #1;
      `CHECK(busLed, lit)
      `CHECK(diagGeneral, exp_general())
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      clockEnable = 1'b1;
      configSwitchPin = 8'h00;
      supplyGoodPin = 1'b1;
      tempSample = '{default: 16'sh0000};
      tempUpdate = 6'h00;
      tempWireBreak = 6'h00;
      tempShort = 6'h00;
      voltSample = '{default: 12'h000};
      voltUpdate = 2'h0;
      lengthError = 1'b0;
      hwError = 1'b0;
      typeError = 1'b0;
      void'($urandom(32'hD7C3));
      for (int m = 0; m < 4; m++)
         run_config(2'(m));
      bus_state(1'b0, 1'b0, 1'b0);
      bus_state(1'b1, 1'b0, 1'b1);
      bus_state(1'b1, 1'b1, 1'b1);
      repeat (BLINK) @(posedge clock);
      #1;
      `CHECK(busLed, 1'b0)
      // Frozen flash must not reach its next lit phase
      @(posedge clock);
      clockEnable <= 1'b0;
      repeat (BLINK) @(posedge clock);
      #1;
      `CHECK(busLed, 1'b0)
      @(posedge clock);
      clockEnable <= 1'b1;
      supplyGoodPin <= 1'b0;
      repeat (5) @(posedge clock);
      #1;
      `CHECK(powerLed, 1'b0)
      give_verdict();
   end

   // Whole run needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge clock);
      failCount++;
      give_verdict();
   end
endmodule
